// [rtl/usibg_usart_irq_baud.sv]
`timescale 1ns/1ns
module usibg_usart_irq_baud (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Transmit shifter side
	input wire logic tx_shift_ready,
	output logic tx_load,
	output logic [7:0] tx_shift_data,
	// Receive shifter and status side
	input wire logic rx_frame_done,
	input wire logic [7:0] rx_frame_data,
	input wire logic rx_error_summary,
	// Baud ticks and serial clock pin
	output logic os_tick,
	output logic bit_tick,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	// Interrupt
	output logic irq
);
	import usibg_pkg::*;

	// Bus handshake state
	logic aw_held, w_held;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
	logic [7:0] next_aw_addr_q;
	logic [31:0] next_w_data_q;
	logic [3:0] next_w_strb_q;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	// Register state
	logic tbe, rbf, eti, eri, eei, mode_sync, mode_cks, err_q;
	logic [PSC_W-1:0] psc;
	logic [DIV_W-1:0] div;
	logic [7:0] txbuf, rxbuf;
	logic [EVT_W-1:0] evt_stat, evt_en, evt_raw;
	logic next_tbe, next_rbf, next_eti, next_eri, next_eei, next_mode_sync, next_mode_cks;
	logic [PSC_W-1:0] next_psc;
	logic [DIV_W-1:0] next_div;
	logic [7:0] next_txbuf, next_rxbuf, next_tx_shift_data;
	logic [EVT_W-1:0] next_evt_stat, next_evt_en;
	logic next_tx_load, next_irq, next_sclk_out, next_sclk_oe, next_os, next_bit;
	// Pin synchroniser and decoded strobes
	logic sclk_meta, sclk_sync, sclk_prev;
	logic do_wr, do_rd, wr_tbuf, rd_rbuf, xfer, wr_ok;
	logic gen_os, gen_bit, gen_clk;
	logic [7:0] ictrl_view;

	// Shared address decode for reads and writes
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == OFS_ICTRL) || (a == OFS_MODE) || (a == OFS_PSC) || (a == OFS_DIV) ||
			(a == OFS_TXBUF) || (a == OFS_RXBUF) || (a == OFS_STAT) || (a == OFS_EVT_STAT) ||
			(a == OFS_EVT_CLR) || (a == OFS_EVT_EN);
	endfunction : is_mapped

	usibg_baud_gen i_usibg_baud_gen (
		.aclk(aclk),
		.aresetn(aresetn),
		.psc_code(psc),
		.divisor(div),
		.sync_mode_select(mode_sync),
		.os_tick(gen_os),
		.bit_tick(gen_bit),
		.gen_clk(gen_clk)
	);

	// Strobes; write waits until both address and data are held
	always_comb begin
		do_wr = aw_held && w_held && !bvalid;
		wr_ok = do_wr && is_mapped(aw_addr_q);
		do_rd = arvalid && arready;
		wr_tbuf = wr_ok && (aw_addr_q == OFS_TXBUF) && w_strb_q[0];
		rd_rbuf = do_rd && (araddr == OFS_RXBUF);
		// Transfer skips a write cycle so the new byte is never lost
		xfer = !tbe && tx_shift_ready && !wr_tbuf;
		ictrl_view = {eei, eri, eti, 3'h0, rbf, tbe};
	end

	// Bus channel next values
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr_q = aw_addr_q;
		next_w_data_q = w_data_q;
		next_w_strb_q = w_strb_q;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_aw_addr_q = awaddr;
		end
		if (wvalid && wready) begin
			next_w_held = 1'b1;
			next_w_data_q = wdata;
			next_w_strb_q = wstrb;
		end
		if (do_wr) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (do_rd) begin
			next_rvalid = 1'b1;
			next_rresp = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			case (araddr)
				OFS_ICTRL: next_rdata = {24'h000000, ictrl_view};
				OFS_MODE: next_rdata = {28'h0000000, mode_cks, 2'h0, mode_sync};
				OFS_PSC: next_rdata = {27'h0000000, psc};
				OFS_DIV: next_rdata = {21'h000000, div};
				OFS_TXBUF: next_rdata = {24'h000000, txbuf};
				OFS_RXBUF: next_rdata = {24'h000000, rxbuf};
				OFS_STAT: next_rdata = {28'h0000000, rx_error_summary, 3'h0};
				OFS_EVT_STAT: next_rdata = {29'h00000000, evt_stat};
				OFS_EVT_EN: next_rdata = {29'h00000000, evt_en};
				default: next_rdata = 32'h00000000;
			endcase
		end else if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
	end

	// Bus channel registers; ready stays low while a word is held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			arready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= 32'h00000000;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr_q <= next_aw_addr_q;
			w_data_q <= next_w_data_q;
			w_strb_q <= next_w_strb_q;
			awready <= !next_aw_held;
			wready <= !next_w_held;
			arready <= !next_rvalid;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end

	// Raw events: flag sets and rising error summary
	always_comb begin
		evt_raw[EVT_TX] = xfer;
		evt_raw[EVT_RX] = rx_frame_done;
		evt_raw[EVT_ERR] = rx_error_summary && !err_q;
	end

	// Sticky event bits; a new event beats a same-cycle clear
	for (genvar i = 0; i < EVT_W; i++) begin : g_evt
		always_comb begin
			next_evt_stat[i] = evt_stat[i];
			if (wr_ok && (aw_addr_q == OFS_EVT_CLR) && w_strb_q[0] && w_data_q[i]) begin
				next_evt_stat[i] = 1'b0;
			end
			if (evt_raw[i]) begin
				next_evt_stat[i] = 1'b1;
			end
		end
	end

	// Register next values; rx full set wins over its clear, but a tx holding write blocks the transfer that would set tx empty
	always_comb begin
		next_eti = eti;
		next_eri = eri;
		next_eei = eei;
		next_mode_sync = mode_sync;
		next_mode_cks = mode_cks;
		next_psc = psc;
		next_div = div;
		next_txbuf = txbuf;
		next_rxbuf = rxbuf;
		next_evt_en = evt_en;
		next_tx_shift_data = tx_shift_data;
		if (wr_ok && w_strb_q[0]) begin
			case (aw_addr_q)
				OFS_ICTRL: begin
					next_eti = w_data_q[BIT_ETI]; // R2
					next_eri = w_data_q[BIT_ERI]; // R2
					next_eei = w_data_q[BIT_EEI]; // R2
				end
				OFS_MODE: begin
					next_mode_sync = w_data_q[BIT_MODE_SYNC]; // R16
					next_mode_cks = w_data_q[BIT_MODE_CKS];
				end
				OFS_PSC: next_psc = w_data_q[PSC_W-1:0]; // R13
				OFS_TXBUF: next_txbuf = w_data_q[7:0];
				OFS_EVT_EN: next_evt_en = w_data_q[EVT_W-1:0];
				default: next_div = div;
			endcase
		end
		if (wr_ok && (aw_addr_q == OFS_DIV)) begin
			if (w_strb_q[0]) begin
				next_div[7:0] = w_data_q[7:0];
			end
			if (w_strb_q[1]) begin
				next_div[DIV_W-1:8] = w_data_q[DIV_W-1:8];
			end
		end
		next_tbe = tbe;
		if (wr_tbuf) begin
			next_tbe = 1'b0; // R4
		end
		next_tx_load = xfer;
		if (xfer) begin
			next_tbe = 1'b1; // R3
			next_tx_shift_data = txbuf;
		end
		next_rbf = rbf;
		if (rd_rbuf) begin
			next_rbf = 1'b0; // R6
		end
		if (rx_frame_done) begin
			next_rbf = 1'b1; // R5
			next_rxbuf = rx_frame_data;
		end
		// Level request from the next flag values so it tracks them
		next_irq = (next_tbe && next_eti) || (next_rbf && next_eri) || // R7 R8 R18
			(rx_error_summary && next_eei) || |(next_evt_stat & next_evt_en); // R9
		// Sync mode: own clock out, or bit timing from the pin
		next_sclk_oe = mode_sync && !mode_cks; // R17
		next_sclk_out = next_sclk_oe && gen_clk; // R14
		next_os = gen_os;
		next_bit = (mode_sync && mode_cks) ? (sclk_prev && !sclk_sync) : gen_bit;
	end

	// Register state, pin synchroniser and outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tbe <= ICTRL_RESET[BIT_TBE]; // R1
			rbf <= ICTRL_RESET[BIT_RBF]; // R1
			eti <= ICTRL_RESET[BIT_ETI]; // R1
			eri <= ICTRL_RESET[BIT_ERI];
			eei <= ICTRL_RESET[BIT_EEI];
			mode_sync <= 1'b0;
			mode_cks <= 1'b0;
			psc <= PSC_RESET;
			div <= DIV_RESET;
			txbuf <= 8'h00;
			rxbuf <= 8'h00;
			evt_stat <= '0;
			evt_en <= '0;
			err_q <= 1'b0;
			tx_load <= 1'b0;
			tx_shift_data <= 8'h00;
			irq <= 1'b0;
			sclk_meta <= 1'b0;
			sclk_sync <= 1'b0;
			sclk_prev <= 1'b0;
			serial_clock_pin_out <= 1'b0;
			serial_clock_pin_oe <= 1'b0;
			os_tick <= 1'b0;
			bit_tick <= 1'b0;
		end else begin
			tbe <= next_tbe;
			rbf <= next_rbf;
			eti <= next_eti;
			eri <= next_eri;
			eei <= next_eei;
			mode_sync <= next_mode_sync;
			mode_cks <= next_mode_cks;
			psc <= next_psc;
			div <= next_div;
			txbuf <= next_txbuf;
			rxbuf <= next_rxbuf;
			evt_stat <= next_evt_stat;
			evt_en <= next_evt_en;
			err_q <= rx_error_summary;
			tx_load <= next_tx_load;
			tx_shift_data <= next_tx_shift_data;
			irq <= next_irq;
			sclk_meta <= serial_clock_pin_in;
			sclk_sync <= sclk_meta;
			sclk_prev <= sclk_sync;
			serial_clock_pin_out <= next_sclk_out;
			serial_clock_pin_oe <= next_sclk_oe;
			os_tick <= next_os;
			bit_tick <= next_bit;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_ictrl_reset_value: assert property ($rose(aresetn) |-> (ictrl_view == ICTRL_RESET)) // R1
		else $error("interrupt control not at reset value");
	chk_flags_write_ignored: assert property ((wr_ok && aw_addr_q == OFS_ICTRL && !xfer && // R2
		!rx_frame_done && !rd_rbuf) |=> ($stable(tbe) && $stable(rbf)))
		else $error("flag changed by software write");
	chk_tbe_on_transfer: assert property (xfer |=> (tbe && tx_load && tx_shift_data == $past(txbuf))) // R3
		else $error("transfer did not set tx empty");
	chk_tbe_write_clear: assert property (wr_tbuf |=> (!tbe && !tx_load)) // R4
		else $error("holding write did not clear tx empty");
	chk_rbf_frame_set: assert property (rx_frame_done |=> (rbf && rxbuf == $past(rx_frame_data))) // R5
		else $error("frame did not set rx full");
	chk_rbf_read_clear: assert property ((rd_rbuf && !rx_frame_done) |=> !rbf) // R6
		else $error("buffer read did not clear rx full");
	chk_irq_tx_rx: assert property (((tbe && eti) || (rbf && eri)) |-> irq) // R7 R8 R18
		else $error("enabled flag without interrupt");
	chk_irq_error: assert property ((eei && $past(rx_error_summary)) |-> irq) // R9
		else $error("error summary without interrupt");
	chk_irq_quiet: assert property ((!eti && !eri && !eei && evt_en == '0) |-> !irq) // R18
		else $error("interrupt with all enables off");
	chk_sclk_drive: assert property ((mode_sync && !mode_cks) [*2] |-> serial_clock_pin_oe) // R17
		else $error("serial clock pin not driven");
endmodule : usibg_usart_irq_baud

// [shared/usibg_pkg.sv]
// What this block does
// R1: Interrupt control resets to 0x01
// R2: Flags read-only, three enables read/write
// R3: Set tx empty on holding-to-shifter transfer
// R4: Clear tx empty on holding buffer write
// R5: Set rx full when frame copied in
// R6: Clear rx full on holding buffer read
// R7: Tx enable gates tx empty interrupt
// R8: Rx enable gates rx full interrupt
// R9: Error enable gates error summary interrupt
// R10: Baud from clock, prescaler and divisor
// R11: Async rate is clock over 16NP
// R12: N equals divisor value plus one
// R13: Prescaler code picks P, halves allowed
// R14: Sync rate is clock over 2NP
// R15: Software uses integer P in sync
// R16: Mode bit: 0 async, 1 sync
// R17: Sync internal clock drives serial clock pin
// R18: Interrupt is OR of enabled flags
package usibg_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_ICTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_PSC = 8'h08;
	localparam logic [7:0] OFS_DIV = 8'h0c;
	localparam logic [7:0] OFS_TXBUF = 8'h10;
	localparam logic [7:0] OFS_RXBUF = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam logic [7:0] OFS_EVT_STAT = 8'h1c;
	localparam logic [7:0] OFS_EVT_CLR = 8'h20;
	localparam logic [7:0] OFS_EVT_EN = 8'h24;
	// Interrupt control field positions
	localparam int BIT_TBE = 0;
	localparam int BIT_RBF = 1;
	localparam int BIT_ETI = 5;
	localparam int BIT_ERI = 6;
	localparam int BIT_EEI = 7;
	localparam logic [7:0] ICTRL_RESET = 8'h01;
	// Mode register fields
	localparam int BIT_MODE_SYNC = 0;
	localparam int BIT_MODE_CKS = 3;
	// Status register field for error summary
	localparam int BIT_ERR = 3;
	// Event bits of the sticky status register
	localparam int EVT_W = 3;
	localparam int EVT_TX = 0;
	localparam int EVT_RX = 1;
	localparam int EVT_ERR = 2;
	// Baud widths and reset values
	localparam int PSC_W = 5;
	localparam int DIV_W = 11;
	localparam logic [PSC_W-1:0] PSC_RESET = 5'h00;
	localparam logic [DIV_W-1:0] DIV_RESET = 11'h000;
	// Oversample ticks per bit, minus one
	localparam logic [3:0] OS_LAST_ASYNC = 4'hf;
	localparam logic [3:0] OS_LAST_SYNC = 4'h1;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : usibg_pkg

// [rtl/usibg_baud_gen.sv]
`timescale 1ns/1ns
module usibg_baud_gen (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Configuration
	input wire logic [usibg_pkg::PSC_W-1:0] psc_code,
	input wire logic [usibg_pkg::DIV_W-1:0] divisor,
	input wire logic sync_mode_select,
	// Ticks and generated clock
	output logic os_tick,
	output logic bit_tick,
	output logic gen_clk
);
	import usibg_pkg::*;

	logic [5:0] acc;
	logic [DIV_W-1:0] ncnt;
	logic [3:0] phase;
	logic [5:0] next_acc;
	logic [DIV_W-1:0] next_ncnt;
	logic [3:0] next_phase;
	logic next_os_tick;
	logic next_bit_tick;
	logic next_gen_clk;
	logic [5:0] p_half;
	logic [5:0] sum;
	logic p_tick;
	logic [3:0] os_last;

	// Fractional prescaler counts in half steps so P may end in .5
	always_comb begin
		p_half = {1'b0, psc_code} + 6'h01; // R13
		sum = acc + 6'h02;
		p_tick = 1'b0;
		next_acc = acc;
		if (psc_code != PSC_RESET) begin // Code zero stops the generator
			if (sum >= p_half) begin
				next_acc = sum - p_half;
				p_tick = 1'b1; // R10
			end else begin
				next_acc = sum;
			end
		end
		os_last = sync_mode_select ? OS_LAST_SYNC : OS_LAST_ASYNC; // R11 R14 R16
		next_ncnt = ncnt;
		next_os_tick = 1'b0;
		if (p_tick) begin
			if (ncnt >= divisor) begin // R12
				next_ncnt = '0;
				next_os_tick = 1'b1;
			end else begin
				next_ncnt = ncnt + 11'h001;
			end
		end
		next_phase = phase;
		next_bit_tick = 1'b0;
		next_gen_clk = gen_clk;
		if (next_os_tick) begin
			next_gen_clk = ~gen_clk;
			if (phase >= os_last) begin
				next_phase = '0;
				next_bit_tick = 1'b1;
			end else begin
				next_phase = phase + 4'h1;
			end
		end
	end

	// Baud counters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc <= '0;
			ncnt <= '0;
			phase <= '0;
			os_tick <= 1'b0;
			bit_tick <= 1'b0;
			gen_clk <= 1'b0;
		end else begin
			acc <= next_acc;
			ncnt <= next_ncnt;
			phase <= next_phase;
			os_tick <= next_os_tick;
			bit_tick <= next_bit_tick;
			gen_clk <= next_gen_clk;
		end
	end

	chk_bit_async_span: assert property (@(posedge aclk) disable iff (!aresetn) // R11
		(bit_tick && !sync_mode_select && $stable(sync_mode_select)) |-> (phase == 4'h0))
		else $error("bit tick without phase wrap");
endmodule : usibg_baud_gen

// [test/usibg_peer_model.sv]
`timescale 1ns/1ns
module usibg_peer_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench controls
	input wire logic stall,
	input wire logic frame_req,
	input wire logic [7:0] frame_byte,
	input wire logic err_in,
	input wire logic pin_low,
	// Block side
	input wire logic tx_load,
	input wire logic serial_clock_pin_out,
	input wire logic serial_clock_pin_oe,
	output logic tx_shift_ready,
	output logic rx_frame_done,
	output logic [7:0] rx_frame_data,
	output logic rx_error_summary,
	output logic serial_clock_pin_in
);
	logic [2:0] busy;
	// Shifter stays busy a few cycles per byte, as a slow line would
	always_ff @(posedge aclk) begin
		if (!aresetn)
			busy <= 3'h0;
		else if (tx_load)
			busy <= 3'h4;
		else if (busy != 3'h0)
			busy <= busy - 3'h1;
	end
	assign tx_shift_ready = !stall && busy == 3'h0 && !tx_load;
	// Frame byte valid only with its pulse; flips otherwise
	always_ff @(posedge aclk) begin
		rx_frame_done <= aresetn && frame_req;
		rx_frame_data <= !aresetn ? 8'h00 : frame_req ? frame_byte : ~rx_frame_data;
	end
	assign rx_error_summary = err_in;
	// Pin pulled high while nobody drives it, unless the far clock pulls it low
	assign serial_clock_pin_in = serial_clock_pin_oe ? serial_clock_pin_out : !pin_low;
endmodule : usibg_peer_model

// [test/usibg_usart_irq_baud_tb_top.sv]
`timescale 1ns/1ns
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
	$display("Error %s expected %h seen %h", what, exp, got); end end
module usibg_usart_irq_baud_tb_top;
	import usibg_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, tx_ready, tx_load, rx_done, rx_err;
	logic os_tick, bit_tick, pin_in, pin_out, pin_oe, irq, stall, frame_req, err_in, pin_low;
	logic [7:0] awaddr, araddr, tx_data, rx_data, frame_byte;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	int bad_count, tests_run;

	usibg_usart_irq_baud i_usibg_usart_irq_baud (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .tx_shift_ready(tx_ready), .tx_load(tx_load), .tx_shift_data(tx_data),
		.rx_frame_done(rx_done), .rx_frame_data(rx_data), .rx_error_summary(rx_err),
		.os_tick(os_tick), .bit_tick(bit_tick), .serial_clock_pin_in(pin_in),
		.serial_clock_pin_out(pin_out), .serial_clock_pin_oe(pin_oe), .irq(irq));
	usibg_peer_model i_usibg_peer_model (.aclk(aclk), .aresetn(aresetn), .stall(stall), .pin_low(pin_low),
		.frame_req(frame_req), .frame_byte(frame_byte), .err_in(err_in), .tx_load(tx_load),
		.serial_clock_pin_out(pin_out), .serial_clock_pin_oe(pin_oe), .tx_shift_ready(tx_ready),
		.rx_frame_done(rx_done), .rx_frame_data(rx_data), .rx_error_summary(rx_err),
		.serial_clock_pin_in(pin_in));

	// Free-running 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic print_verdict();
		$display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	task automatic hang();
		bad_count++;
		$display("Error handshake expected done seen timeout");
		print_verdict();
	endtask : hang

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		// One free edge so back-to-back calls never drive a signal twice at once
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		rs = bresp;
		bready <= 1'b0;
		if (n == 40) hang();
	endtask : wr

	task automatic rd_reg(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (n == 40) hang();
	endtask : rd_reg

	// Third interval is clean even right after a reprogram
	task automatic period(input int exp);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (bit_tick !== 1'b1 && n < 700);
			if (n == 700) hang();
		end
		`CHK("bit period", exp, n)
	endtask : period

	task automatic t_regs();
		rd_reg(OFS_ICTRL);
		`CHK("ictrl reset", 32'h01, rd)
		`CHK("irq reset", 1'b0, irq)
		wr(OFS_ICTRL, 32'hff);
		rd_reg(OFS_ICTRL);
		`CHK("ictrl all set", 32'he1, rd)
		`CHK("irq tx enabled", 1'b1, irq)
		wr(OFS_ICTRL, 32'h00);
		rd_reg(OFS_ICTRL);
		`CHK("ictrl cleared", 32'h01, rd)
		`CHK("irq all masked", 1'b0, irq)
		wr(8'h40, 32'hff);
		`CHK("unmapped write resp", 2'h2, rs)
		rd_reg(8'h40);
		`CHK("unmapped read resp", 2'h2, rs)
		`CHK("unmapped read data", 32'h0, rd)
		$display("test registers done");
	endtask : t_regs

	task automatic t_tx();
		int n;
		stall <= 1'b1;
		wr(OFS_TXBUF, 32'h5a);
		rd_reg(OFS_ICTRL);
		`CHK("tx empty cleared", 32'h00, rd)
		wr(OFS_ICTRL, 32'h20);
		`CHK("irq tx waiting", 1'b0, irq)
		stall <= 1'b0;
		for (n = 0; n < 20 && tx_load !== 1'b1; n++) @(posedge aclk);
		if (n == 20) hang();
		`CHK("shift data", 8'h5a, tx_data)
		tick(1);
		`CHK("irq tx empty", 1'b1, irq)
		rd_reg(OFS_ICTRL);
		`CHK("tx empty set", 32'h21, rd)
		$display("test transmit done");
	endtask : t_tx

	task automatic t_rx();
		wr(OFS_ICTRL, 32'h40);
		`CHK("irq rx idle", 1'b0, irq)
		frame_byte <= 8'hc3;
		frame_req <= 1'b1;
		tick(1);
		frame_req <= 1'b0;
		tick(3);
		`CHK("irq rx full", 1'b1, irq)
		rd_reg(OFS_ICTRL);
		`CHK("rx full set", 32'h43, rd)
		rd_reg(OFS_RXBUF);
		`CHK("rx data", 32'hc3, rd)
		rd_reg(OFS_ICTRL);
		`CHK("rx full cleared", 32'h41, rd)
		`CHK("irq rx read", 1'b0, irq)
		$display("test receive done");
	endtask : t_rx

	task automatic t_err();
		wr(OFS_ICTRL, 32'h80);
		err_in <= 1'b1;
		tick(3);
		`CHK("irq error", 1'b1, irq)
		wr(OFS_ICTRL, 32'h00);
		`CHK("irq error masked", 1'b0, irq)
		err_in <= 1'b0;
		rd_reg(OFS_EVT_STAT);
		`CHK("sticky events", 32'h7, rd)
		wr(OFS_EVT_EN, 32'h4);
		`CHK("irq event", 1'b1, irq)
		wr(OFS_EVT_CLR, 32'h7);
		rd_reg(OFS_EVT_STAT);
		`CHK("events cleared", 32'h0, rd)
		`CHK("irq event cleared", 1'b0, irq)
		$display("test errors and events done");
	endtask : t_err

	task automatic t_baud();
		logic p;
		int k;
		wr(OFS_DIV, 32'h1);
		wr(OFS_PSC, 32'hc);
		wr(OFS_MODE, 32'h0);
		period(208);
		`CHK("pin enable async", 1'b0, pin_oe)
		wr(OFS_PSC, 32'h3);
		wr(OFS_MODE, 32'h1);
		period(8);
		`CHK("pin enable sync", 1'b1, pin_oe)
		// Generated clock flips every N*P clocks, one oversample tick each
		p = pin_out;
		k = 0;
		repeat (4) begin
			@(posedge aclk);
			k += os_tick;
		end
		`CHK("sync os ticks", 1, k)
		`CHK("pin clock toggles", ~p, pin_out)
		wr(OFS_MODE, 32'h9);
		// Pin enable follows the mode register one cycle later
		tick(1);
		`CHK("pin enable external", 1'b0, pin_oe)
		// Let the last driven edges drain out of the synchroniser first
		tick(4);
		pin_low <= 1'b1;
		for (k = 0; k < 8 && bit_tick !== 1'b1; k++) @(posedge aclk);
		`CHK("external clock delay", 4, k)
		$display("test baud done");
	endtask : t_baud

	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, stall, frame_req, err_in, pin_low} = '0;
		{awaddr, araddr, frame_byte, wdata, wstrb} = '0;
		tick(3);
		aresetn <= 1'b1;
		tick(1);
		t_regs();
		t_tx();
		t_rx();
		t_err();
		t_baud();
		print_verdict();
	end
endmodule : usibg_usart_irq_baud_tb_top
